// ---- common/csl_pkg.sv ----
// Purpose: shared types and constants for the controller status light decoder
// Assumes: 125 MHz system clock
// Notes: enumerations are one-hot; any other code is treated as illegal
package csl_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CSL_CLK_PERIOD_NS = 8;
  localparam int CSL_BLINK_HALF_MS = 250;
  localparam int CSL_NS_PER_MS = 1000000;
  localparam int CSL_BLINK_HALF_CYC = (CSL_BLINK_HALF_MS * CSL_NS_PER_MS) / CSL_CLK_PERIOD_NS;
  localparam int CSL_CNT_W = 32;
  localparam logic [CSL_CNT_W-1:0] CSL_CNT_ZERO = 32'h0000_0000;
  localparam logic [CSL_CNT_W-1:0] CSL_CNT_ONE = 32'h0000_0001;

  // ----------------------------------------
  // processor states
  // ----------------------------------------
  typedef enum logic [4:0] {
    CSL_PS_SELFTEST = 5'h01,
    CSL_PS_UNCONFIGURED = 5'h02,
    CSL_PS_STOP = 5'h04,
    CSL_PS_RUN = 5'h08,
    CSL_PS_HALT = 5'h10
  } csl_proc_state_t;

  // ----------------------------------------
  // role-select switch positions
  // ----------------------------------------
  typedef enum logic [2:0] {
    CSL_SW_A = 3'h1,
    CSL_SW_B = 3'h2,
    CSL_SW_CLEAR = 3'h4
  } csl_switch_t;

  // ----------------------------------------
  // redundancy roles
  // ----------------------------------------
  typedef enum logic [3:0] {
    CSL_ROLE_PRIMARY = 4'h1,
    CSL_ROLE_STANDBY = 4'h2,
    CSL_ROLE_WAIT = 4'h4,
    CSL_ROLE_NONE = 4'h8
  } csl_role_t;

  // ----------------------------------------
  // lamp drive, one bit per lamp element
  // ----------------------------------------
  typedef struct packed {
    logic run;
    logic ns_green;
    logic ns_red;
    logic io_red;
    logic sel_a;
    logic sel_b;
    logic partner_run;
    logic primary;
    logic standby;
  } csl_lamps_t;

  localparam csl_lamps_t CSL_LAMPS_DARK = '0;

  // ----------------------------------------
  // inputs grouped
  // ----------------------------------------
  typedef struct packed {
    logic addr_valid;
    logic conn_up;
    logic conn_timeout;
    logic conn_restored;
    logic io_fault;
  } csl_net_t;

  typedef struct packed {
    csl_switch_t local_sw;
    csl_switch_t partner_sw;
    logic partner_running;
    logic sync_link_ok;
    logic remote_io_link_ok;
    csl_role_t local_role;
    csl_role_t partner_role;
  } csl_pair_t;

endpackage

// ---- hdl/csl_decoder.sv ----
// Purpose: decode processor and redundant-pair state into front-panel lamp patterns
// Assumes: all inputs synchronous to sys_clk; conn_timeout and conn_restored are pulses
// Notes: every lamp output is registered; blinking lamps share one phase
//
// How it works
// R1: processor state selects which lamps decode
// R2: network lamp dark, blink or steady green
// R3: timed-out connection blinks network lamp red
// R4: fault lamp steady red on module fault in stop or run state
// R5: lamp A steady when local A, partner B
// R6: both A blinks A; Clear blinks both
// R7: lamp B steady when local B, partner A
// R8: both B blinks B, A stays dark
// R9: select lamps dark for other positions
// R10: partner lamp steady, blinking, or off
// R11: primary lamp steady, blinking in wait, dark
// R12: standby lamp steady, blinking or dark
// R13: primary with waiting partner lamp pairing
// R14: run lamp steady in run state
// R15: all blinking shares one tick phase
`timescale 1ns/1ps
module csl_decoder
  import csl_pkg::*;
#(
  parameter int BLINK_HALF_CYCLES = CSL_BLINK_HALF_CYC
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire csl_proc_state_t proc_state, // processor state
  input wire csl_net_t net, // network and fault status
  input wire csl_pair_t pair, // redundant pair status
  output csl_lamps_t lamps // lamp drive
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [CSL_CNT_W-1:0] blink_cnt;
    logic phase;
    logic timeout_flag;
    csl_lamps_t lamps;
  } csl_state_t;

  localparam logic [CSL_CNT_W-1:0] HALF_LAST = CSL_CNT_W'(BLINK_HALF_CYCLES - 1);

  csl_state_t st;
  csl_state_t next_st;
  logic configured;
  logic partner_lost;

  always_comb begin
    next_st = st;
    // shared blink tick
    if (st.blink_cnt >= HALF_LAST) begin
      next_st.blink_cnt = CSL_CNT_ZERO; // R15
      next_st.phase = ~st.phase; // R15
    end else begin
      next_st.blink_cnt = st.blink_cnt + CSL_CNT_ONE;
    end

    // timeout latch, set wins over clear
    if (net.conn_timeout) begin
      next_st.timeout_flag = 1'b1; // R3
    end else if (net.conn_restored) begin
      next_st.timeout_flag = 1'b0; // R3
    end

    configured = (proc_state == CSL_PS_STOP) || (proc_state == CSL_PS_RUN); // R1
    partner_lost = !pair.sync_link_ok && !pair.remote_io_link_ok;
    next_st.lamps = CSL_LAMPS_DARK;

    next_st.lamps.run = (proc_state == CSL_PS_RUN); // R14

    // network status lamp
    if (st.timeout_flag) begin
      next_st.lamps.ns_red = st.phase; // R3
    end else if (configured || proc_state == CSL_PS_HALT) begin
      if (!net.addr_valid) begin
        next_st.lamps.ns_green = 1'b0; // R2
      end else if (net.conn_up) begin
        next_st.lamps.ns_green = 1'b1; // R2
      end else begin
        next_st.lamps.ns_green = st.phase; // R2
      end
    end

    next_st.lamps.io_red = configured && net.io_fault; // R4

    // role-select lamps
    unique case (pair.local_sw)
      CSL_SW_A: begin
        if (pair.partner_sw == CSL_SW_B) begin
          next_st.lamps.sel_a = 1'b1; // R5
        end else if (pair.partner_sw == CSL_SW_A) begin
          next_st.lamps.sel_a = st.phase; // R6
        end
      end
      CSL_SW_B: begin
        if (pair.partner_sw == CSL_SW_A) begin
          next_st.lamps.sel_b = 1'b1; // R7
        end else if (pair.partner_sw == CSL_SW_B) begin
          next_st.lamps.sel_b = st.phase; // R8
        end
      end
      CSL_SW_CLEAR: begin
        next_st.lamps.sel_a = st.phase; // R6
        next_st.lamps.sel_b = st.phase; // R6
      end
      default: begin
        next_st.lamps.sel_a = 1'b0; // R9
        next_st.lamps.sel_b = 1'b0; // R9
      end
    endcase

    // partner run lamp
    if (partner_lost) begin
      next_st.lamps.partner_run = 1'b0; // R10
    end else if (pair.partner_running) begin
      next_st.lamps.partner_run = 1'b1; // R10
    end else begin
      next_st.lamps.partner_run = st.phase; // R10
    end

    // primary and standby lamps
    unique case (pair.local_role)
      CSL_ROLE_PRIMARY: begin
        next_st.lamps.primary = 1'b1; // R11
        if (pair.partner_role != CSL_ROLE_STANDBY) begin
          next_st.lamps.standby = st.phase; // R12 R13
        end
      end
      CSL_ROLE_STANDBY: begin
        next_st.lamps.standby = 1'b1; // R12
      end
      CSL_ROLE_WAIT: begin
        // waiting beside a primary: primary lamp stays dark
        if (pair.partner_role != CSL_ROLE_PRIMARY) begin
          next_st.lamps.primary = st.phase; // R11
        end
        next_st.lamps.standby = st.phase; // R12 R13
      end
      CSL_ROLE_NONE: begin
        next_st.lamps.primary = 1'b0; // R11
      end
      default: begin
        next_st.lamps.primary = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lamps = st.lamps;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seq_timeout_seen;
    net.conn_timeout ##1 !net.conn_restored;
  endsequence

  sequence seq_clear_switch;
    pair.local_sw == CSL_SW_CLEAR;
  endsequence

  run_lamp_a: assert property (proc_state == CSL_PS_RUN |=> lamps.run) // R14
    else $error("run lamp not lit in run state");
  ns_steady_a: assert property (configured && !st.timeout_flag && net.addr_valid && net.conn_up // R2
      |=> lamps.ns_green && !lamps.ns_red)
    else $error("network lamp not steady green");
  ns_red_blink_a: assert property (seq_timeout_seen |=> !lamps.ns_green && lamps.ns_red == $past(st.phase)) // R3
    else $error("network lamp not blinking red after timeout");
  io_fault_a: assert property (configured && net.io_fault |=> lamps.io_red) // R4
    else $error("fault lamp not red");
  sel_steady_a: assert property (pair.local_sw == CSL_SW_A && pair.partner_sw == CSL_SW_B // R5
      |=> lamps.sel_a && !lamps.sel_b)
    else $error("lamp A not steady");
  sel_a_blink_a: assert property (pair.local_sw == CSL_SW_A && pair.partner_sw == CSL_SW_A // R6
      |=> !lamps.sel_b && lamps.sel_a == $past(st.phase))
    else $error("lamp A not blinking alone");
  sel_clear_a: assert property (seq_clear_switch |=> lamps.sel_a == lamps.sel_b && lamps.sel_a == $past(st.phase)) // R6
    else $error("clear position not blinking both lamps");
  sel_b_steady_a: assert property (pair.local_sw == CSL_SW_B && pair.partner_sw == CSL_SW_A // R7
      |=> lamps.sel_b && !lamps.sel_a)
    else $error("lamp B not steady");
  sel_b_blink_a: assert property (pair.local_sw == CSL_SW_B && pair.partner_sw == CSL_SW_B // R8
      |=> !lamps.sel_a && lamps.sel_b == $past(st.phase))
    else $error("lamp B not blinking alone");
  sel_dark_a: assert property (pair.local_sw == CSL_SW_B |=> !lamps.sel_a) // R9
    else $error("lamp A lit for position B");
  sel_b_dark_a: assert property (pair.local_sw == CSL_SW_A |=> !lamps.sel_b) // R9
    else $error("lamp B lit for position A");
  partner_off_a: assert property (partner_lost |=> !lamps.partner_run) // R10
    else $error("partner lamp lit with both links lost");
  partner_steady_a: assert property (!partner_lost && pair.partner_running |=> lamps.partner_run) // R10
    else $error("partner lamp not steady while partner runs");
  primary_pair_a: assert property (pair.local_role == CSL_ROLE_PRIMARY && pair.partner_role == CSL_ROLE_WAIT // R11 R13
      |=> lamps.primary && lamps.standby == $past(st.phase))
    else $error("primary pairing pattern wrong");
  wait_pair_a: assert property (pair.local_role == CSL_ROLE_WAIT && pair.partner_role == CSL_ROLE_PRIMARY // R13
      |=> !lamps.primary && lamps.standby == $past(st.phase))
    else $error("waiting pairing pattern wrong");
  standby_on_a: assert property (pair.local_role == CSL_ROLE_STANDBY |=> lamps.standby && !lamps.primary) // R12
    else $error("standby lamp not steady");
  blink_tick_a: assert property (st.blink_cnt == HALF_LAST // R15
      |=> st.blink_cnt == CSL_CNT_ZERO && st.phase != $past(st.phase))
    else $error("blink phase did not toggle at tick");
  conf_state_a: assert property (proc_state == CSL_PS_UNCONFIGURED && !st.timeout_flag // R1
      |=> !lamps.ns_green && !lamps.io_red)
    else $error("unconfigured state lit network or fault lamp");
  timeout_set_a: assert property (net.conn_timeout |=> st.timeout_flag) // R3
    else $error("timeout flag not set");
  timeout_clear_a: assert property (net.conn_restored && !net.conn_timeout |=> !st.timeout_flag) // R3
    else $error("timeout flag not cleared on restore");
  fault_dark_a: assert property (!configured |=> !lamps.io_red) // R4
    else $error("fault lamp lit outside stop or run");

endmodule

// ---- verification/controller_status_light_decoder_test.sv ----
// Purpose: self-checking bench for the status light decoder
// Assumes: short blink half period of 4 cycles
// Notes: each scenario sets inputs, then watches the lamps for two blink periods
`timescale 1ns/1ps
module controller_status_light_decoder_test;
  import csl_pkg::*;
  localparam int HALF = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic obs_clr = 1'b0;
  csl_proc_state_t proc_state = CSL_PS_SELFTEST;
  csl_net_t net = '0;
  csl_pair_t pair = '0;
  csl_lamps_t lamps;
  csl_lamps_t seen_on;
  csl_lamps_t seen_off;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;

  always #4 sys_clk = ~sys_clk;

  csl_decoder #(.BLINK_HALF_CYCLES(HALF)) dut_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .proc_state(proc_state),
    .net(net),
    .pair(pair),
    .lamps(lamps)
  );

  csl_operator op_u (
    .sys_clk(sys_clk),
    .obs_clr(obs_clr),
    .lamps(lamps),
    .seen_on(seen_on),
    .seen_off(seen_off)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // lk packs running, sync link ok, remote link ok
  function automatic csl_pair_t mk(input csl_switch_t ls, input csl_switch_t ps, input logic [2:0] lk,
                                   input csl_role_t lr, input csl_role_t pr);
    csl_pair_t p;
    p.local_sw = ls;
    p.partner_sw = ps;
    {p.partner_running, p.sync_link_ok, p.remote_io_link_ok} = lk;
    p.local_role = lr;
    p.partner_role = pr;
    return p;
  endfunction

  // apply inputs, drop pulses, settle, then watch two blink periods
  task automatic scen(input csl_proc_state_t ps, input logic [4:0] n, input csl_pair_t p,
                      input logic [8:0] st, input logic [8:0] bl);
    @(posedge sys_clk);
    proc_state <= ps;
    net <= csl_net_t'(n);
    pair <= p;
    @(posedge sys_clk);
    net.conn_timeout <= 1'b0;
    net.conn_restored <= 1'b0;
    repeat (3) @(posedge sys_clk);
    obs_clr <= 1'b1;
    @(posedge sys_clk);
    obs_clr <= 1'b0;
    repeat (4 * HALF) @(posedge sys_clk);
    #1;
    check(seen_on, st | bl);
    check(seen_off, ~st);
  endtask

  // ----------------------------------------
  // hang guard
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    scen(CSL_PS_RUN, 5'h18, mk(CSL_SW_A, CSL_SW_B, 3'h7, CSL_ROLE_PRIMARY, CSL_ROLE_STANDBY),
         9'h196, 9'h000);
    scen(CSL_PS_STOP, 5'h11, mk(CSL_SW_A, CSL_SW_A, 3'h3, CSL_ROLE_WAIT, CSL_ROLE_PRIMARY),
         9'h020, 9'h095);
    scen(CSL_PS_HALT, 5'h01, mk(CSL_SW_B, CSL_SW_B, 3'h4, CSL_ROLE_WAIT, CSL_ROLE_STANDBY),
         9'h000, 9'h00b);
    scen(CSL_PS_RUN, 5'h18, mk(CSL_SW_CLEAR, CSL_SW_B, 3'h6, CSL_ROLE_STANDBY, CSL_ROLE_PRIMARY),
         9'h185, 9'h018);
    scen(CSL_PS_UNCONFIGURED, 5'h18, mk(CSL_SW_B, CSL_SW_A, 3'h7, CSL_ROLE_PRIMARY, CSL_ROLE_WAIT),
         9'h00e, 9'h001);
    scen(CSL_PS_SELFTEST, 5'h18, mk(CSL_SW_A, CSL_SW_CLEAR, 3'h3, CSL_ROLE_NONE, CSL_ROLE_STANDBY),
         9'h000, 9'h004);
    scen(CSL_PS_RUN, 5'h1c, mk(CSL_SW_A, CSL_SW_B, 3'h7, CSL_ROLE_PRIMARY, CSL_ROLE_STANDBY),
         9'h116, 9'h040);
    scen(CSL_PS_RUN, 5'h1e, mk(CSL_SW_A, CSL_SW_B, 3'h7, CSL_ROLE_PRIMARY, CSL_ROLE_STANDBY),
         9'h116, 9'h040);
    scen(CSL_PS_RUN, 5'h1a, mk(CSL_SW_A, CSL_SW_B, 3'h7, CSL_ROLE_PRIMARY, CSL_ROLE_STANDBY),
         9'h196, 9'h000);
    // illegal switch and role codes leave those lamps dark
    scen(CSL_PS_STOP, 5'h10, mk(csl_switch_t'(3'h0), CSL_SW_A, 3'h7, csl_role_t'(4'h0), CSL_ROLE_PRIMARY),
         9'h004, 9'h080);
    scen(CSL_PS_RUN, 5'h1c, mk(CSL_SW_A, CSL_SW_B, 3'h7, CSL_ROLE_PRIMARY, CSL_ROLE_STANDBY),
         9'h116, 9'h040);
    // mid-run reset drops the latched timeout without a restore
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    scen(CSL_PS_RUN, 5'h18, mk(CSL_SW_A, CSL_SW_B, 3'h7, CSL_ROLE_PRIMARY, CSL_ROLE_STANDBY),
         9'h196, 9'h000);
    wrap_up();
  end
endmodule

// ---- verification/csl_operator.sv ----
// Purpose: operator model that watches the front-panel lamps
// Assumes: lamps sampled on sys_clk
// Notes: lit and dark sightings gathered since the last obs_clr
`timescale 1ns/1ps
module csl_operator
  import csl_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic obs_clr, // restart observation
  input wire csl_lamps_t lamps, // lamp drive seen
  output csl_lamps_t seen_on, // lamp lit at some time
  output csl_lamps_t seen_off // lamp dark at some time
);
  // steady lamps are never seen dark, blinking ones are seen both ways
  always_ff @(posedge sys_clk) begin
    if (obs_clr) begin
      seen_on <= CSL_LAMPS_DARK;
      seen_off <= CSL_LAMPS_DARK;
    end else begin
      seen_on <= csl_lamps_t'(seen_on | lamps);
      seen_off <= csl_lamps_t'(seen_off | ~lamps);
    end
  end
endmodule
